// File: core/asr_pkg.sv
package asr_pkg;
  // pin widths of the memory in its two organisations
  localparam int ADDR_W = 22;          // single-bit words
  localparam int ADDR_W_WIDE = 20;     // four-bit words
  localparam int DATA_W = 4;
  localparam int CNT_W = 4;

  // clock period in picoseconds
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_NS = 1000;

  // device timing, nanoseconds as printed, fast and slow grade
  localparam int T_ACC_FAST_NS = 12;   // address / select access
  localparam int T_ACC_SLOW_NS = 15;
  localparam int T_OE_ACC_FAST_NS = 6; // output enable access
  localparam int T_OE_ACC_SLOW_NS = 7;
  localparam int T_WP_OE_HIGH_NS = 10; // write pulse with oe high
  localparam int T_SEL_SU_NS = 10;     // select low before write end
  localparam int T_DIS_FAST_NS = 6;    // output float after oe high
  localparam int T_DIS_SLOW_NS = 7;
  localparam int T_REC_NS = 1;         // write recovery
  localparam int T_DV_NS = 3;          // data valid after address change

  // least times round up to whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // synchroniser depth and the stage count before data is trusted
  localparam int SYNC_STAGES = 3;

  // idle pin levels
  localparam logic PIN_INACTIVE = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_SETUP = 3'b001,
    ASR_WPULSE = 3'b010,
    ASR_WREC = 3'b011,
    ASR_RACC = 3'b100,
    ASR_RCAP = 3'b101,
    ASR_RFLOAT = 3'b110
  } asr_state_t;
endpackage

// File: core/asr_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two and
// three agree, so a single unsettled sample is never taken
module asr_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out,
  output logic stable_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // capture chain; stage1 feeds stage2 only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accepted value follows only on agreement
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_out <= '0;
      stable_out <= 1'b0;
    end else begin
      stable_out <= (stage2 == stage3);
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end
endmodule // asr_sync

// File: core/asr_ctrl.sv
`timescale 1ns/1ps
module asr_ctrl
  import asr_pkg::*;
#(
  parameter bit FAST_GRADE = 1'b1,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  // user side
  input wire logic req_in,
  input wire logic write_in,
  input wire logic wide_mode_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic ready_out,
  output logic rvalid_out,
  output logic [DW-1:0] rdata_out,
  output logic wdone_out,
  // memory pins
  output logic [AW-1:0] mem_addr_out,
  output logic mem_sel_n_out,
  output logic mem_we_n_out,
  output logic mem_oe_n_out,
  output logic [DW-1:0] mem_d_out,
  output logic width_select_out,
  input wire logic [DW-1:0] mem_q_in
);
  // per-grade figures in cycles
  localparam int ACC_NS = FAST_GRADE ? T_ACC_FAST_NS : T_ACC_SLOW_NS;
  localparam int OE_NS = FAST_GRADE ? T_OE_ACC_FAST_NS : T_OE_ACC_SLOW_NS;
  localparam int DIS_NS = FAST_GRADE ? T_DIS_FAST_NS : T_DIS_SLOW_NS;
  localparam int ACC_CYC = min_cycles(ACC_NS);
  localparam int OE_CYC = min_cycles(OE_NS);
  // oe is kept high in writes, so the shorter pulse applies
  localparam int WP_BASE = min_cycles(T_WP_OE_HIGH_NS);
  localparam int SEL_CYC = min_cycles(T_SEL_SU_NS);
  localparam int WP_CYC = (WP_BASE > SEL_CYC) ? WP_BASE : SEL_CYC;
  localparam int REC_CYC = min_cycles(T_REC_NS);
  localparam int DIS_CYC = min_cycles(DIS_NS);
  localparam int DV_CYC = min_cycles(T_DV_NS);
  // wait covers the slower of select and output enable access
  localparam int RD_WAIT = (ACC_CYC > OE_CYC) ? ACC_CYC : OE_CYC;
  localparam int RD_CYC = RD_WAIT + SYNC_STAGES;
  localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC_CYC);
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] DIS_CNT = CNT_W'(DIS_CYC);
  localparam logic [CNT_W-1:0] DV_CNT = CNT_W'(DV_CYC);

  asr_state_t state;
  asr_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic op_write;
  logic [DW-1:0] q_sync;
  logic q_stable;
  logic cnt_done;

  assign cnt_done = (cnt == CNT_ZERO);

  // returned data passes the three-stage synchroniser
  asr_sync #(
    .WIDTH(DW)
  ) u_q_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in(mem_q_in),
    .sync_out(q_sync),
    .stable_out(q_stable)
  );

  // requests are taken only in idle, so address holds for a whole access
  assign ready_out = (state == ASR_IDLE);

  // next state and counter
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!cnt_done) begin
      next_cnt = cnt - CNT_ONE;
    end
    unique case (state)
      ASR_IDLE: begin
        if (req_in) begin
          next_state = ASR_SETUP;
        end
      end
      ASR_SETUP: begin
        if (op_write) begin
          next_state = ASR_WPULSE;
          next_cnt = WP_CNT - CNT_ONE;
        end else begin
          next_state = ASR_RACC;
          next_cnt = RD_CNT - CNT_ONE;
        end
      end
      ASR_WPULSE: begin
        if (cnt_done) begin
          next_state = ASR_WREC;
          next_cnt = REC_CNT - CNT_ONE;
        end
      end
      ASR_WREC: begin
        if (cnt_done) begin
          next_state = ASR_IDLE;
        end
      end
      ASR_RACC: begin
        if (cnt_done) begin
          next_state = ASR_RCAP;
        end
      end
      ASR_RCAP: begin
        if (q_stable) begin
          next_state = ASR_RFLOAT;
          next_cnt = (DIS_CNT > DV_CNT) ? DIS_CNT : DV_CNT;
        end
      end
      ASR_RFLOAT: begin
        if (cnt_done) begin
          next_state = ASR_IDLE;
        end
      end
      default: begin
        next_state = ASR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ASR_IDLE;
      cnt <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // request capture: address, data, direction held until idle again
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_write <= 1'b0;
      mem_addr_out <= '0;
      mem_d_out <= '0;
    end else if (state == ASR_IDLE && req_in) begin
      op_write <= write_in;
      mem_addr_out <= addr_in;
      mem_d_out <= wdata_in;
    end
  end

  // organisation pin changes only while the memory is deselected
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      width_select_out <= 1'b0;
    end else if (state == ASR_IDLE) begin
      width_select_out <= wide_mode_in;
    end
  end

  // select is low only in an access; idle stays deselected for low power
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_sel_n_out <= PIN_INACTIVE;
    end else begin
      unique case (next_state)
        ASR_WPULSE, ASR_RACC, ASR_RCAP: begin
          mem_sel_n_out <= PIN_ACTIVE;
        end
        default: begin
          mem_sel_n_out <= PIN_INACTIVE;
        end
      endcase
    end
  end

  // write enable falls together with select and rises with it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_we_n_out <= PIN_INACTIVE;
    end else begin
      mem_we_n_out <= (next_state == ASR_WPULSE) ? PIN_ACTIVE
                                                  : PIN_INACTIVE;
    end
  end

  // output enable only in reads, never during a write
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_oe_n_out <= PIN_INACTIVE;
    end else begin
      mem_oe_n_out <= (next_state == ASR_RACC || next_state == ASR_RCAP)
                      ? PIN_ACTIVE : PIN_INACTIVE;
    end
  end

  // read data capture; narrow mode returns bit zero only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= '0;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= 1'b0;
      if (state == ASR_RCAP && q_stable) begin
        rvalid_out <= 1'b1;
        if (width_select_out) begin
          rdata_out <= q_sync;
        end else begin
          rdata_out <= {{(DW-1){1'b0}}, q_sync[0]};
        end
      end
    end
  end

  // write completion pulse at the end of recovery
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdone_out <= 1'b0;
    end else begin
      wdone_out <= (state == ASR_WREC) && cnt_done;
    end
  end
endmodule // asr_ctrl

// File: verification/asr_ctrl_asserts.sv
`timescale 1ns/1ps
// pin order and timing checks on the controller's memory side
module asr_ctrl_asserts
  import asr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [AW-1:0] mem_addr_out,
  input wire logic mem_sel_n_out,
  input wire logic mem_we_n_out,
  input wire logic mem_oe_n_out,
  input wire logic [DW-1:0] mem_d_out,
  input wire logic width_select_out,
  input wire logic wdone_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // address frozen while selected
  addr_hold_a: assert property (
    !mem_sel_n_out && $past(!mem_sel_n_out) |-> $stable(mem_addr_out))
    else $error("address moved while selected");
  // write pulse of three cycles covers the 10 ns minimum
  wpulse_len_a: assert property (
    $fell(mem_we_n_out) |-> (!mem_we_n_out)[*3])
    else $error("write pulse too short");
  // select low three cycles before the write ends
  sel_setup_a: assert property (
    $rose(mem_we_n_out) |-> $past(!mem_sel_n_out, 3))
    else $error("select setup too short");
  // write enable falls only with select low, output stays off
  we_sel_a: assert property (
    $fell(mem_we_n_out) |-> !mem_sel_n_out && mem_oe_n_out)
    else $error("write without select");
  // done pulse one cycle after the write ends
  wdone_a: assert property (
    $rose(mem_we_n_out) |=> wdone_out)
    else $error("write done missing");
  // data and address steady through the pulse
  dhold_a: assert property (
    !mem_we_n_out && $past(!mem_we_n_out) |->
      $stable(mem_d_out) && $stable(mem_addr_out))
    else $error("data moved in write");
  // read held for the 12 ns access
  oe_acc_a: assert property (
    $fell(mem_oe_n_out) |-> (!mem_oe_n_out && !mem_sel_n_out)[*3])
    else $error("read access too short");
  // organisation changes only while deselected
  width_a: assert property (
    $changed(width_select_out) |-> mem_sel_n_out)
    else $error("width changed while selected");
endmodule // asr_ctrl_asserts

// File: verification/asr_sram_model.sv
`timescale 1ns/1ps
// behavioural memory on the far side of the controller pins
module asr_sram_model
  import asr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic [AW-1:0] addr_in,
  input wire logic sel_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [DW-1:0] d_in,
  input wire logic width_select_in,
  output logic [DW-1:0] q_out
);
  logic [DW-1:0] mem [logic [AW:0]];
  logic [DW-1:0] w;
  logic wr_act;
  int dly_ns = 2;
  initial q_out = '0;
  // write while both enables low; contents kept with no clock
  assign wr_act = !sel_n_in && !we_n_in;
  // latch at whichever enable rises first
  always @(negedge wr_act) begin
    mem[{width_select_in, addr_in}] = width_select_in ? d_in :
      {{(DW-1){1'b0}}, d_in[0]};
  end
  // drive only in a read; released output shows the inverse
  always @(sel_n_in, we_n_in, oe_n_in, addr_in, width_select_in) begin
    w = mem.exists({width_select_in, addr_in}) ?
      mem[{width_select_in, addr_in}] : '0;
    if (!sel_n_in && we_n_in && !oe_n_in)
      q_out <= #(dly_ns) width_select_in ? w : {~q_out[DW-1:1], w[0]};
    else
      q_out <= ~q_out;
  end
endmodule // asr_sram_model

// File: verification/tb_async_static_ram_4mbit.sv
`timescale 1ns/1ps
module tb_async_static_ram_4mbit;
  import asr_pkg::*;
  logic clk_in = 1'b0, arst_n_in = 1'b0, req_in = 1'b0, write_in = 1'b0;
  logic wide_mode_in = 1'b0, ready_out, rvalid_out, wdone_out;
  logic mem_sel_n_out, mem_we_n_out, mem_oe_n_out, width_select_out;
  logic [ADDR_W-1:0] addr_in = '0, mem_addr_out;
  logic [DATA_W-1:0] wdata_in = '0, rdata_out, mem_d_out, mem_q_in;
  int failures = 0, n_checks = 0, n;
  always #2 clk_in = ~clk_in;
  asr_ctrl asr_ctrl_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .req_in(req_in), .write_in(write_in), .wide_mode_in(wide_mode_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .ready_out(ready_out),
    .rvalid_out(rvalid_out), .rdata_out(rdata_out), .wdone_out(wdone_out),
    .mem_addr_out(mem_addr_out), .mem_sel_n_out(mem_sel_n_out),
    .mem_we_n_out(mem_we_n_out), .mem_oe_n_out(mem_oe_n_out),
    .mem_d_out(mem_d_out), .width_select_out(width_select_out),
    .mem_q_in(mem_q_in));
  asr_sram_model asr_sram_model_inst (.addr_in(mem_addr_out),
    .sel_n_in(mem_sel_n_out), .we_n_in(mem_we_n_out),
    .oe_n_in(mem_oe_n_out), .d_in(mem_d_out),
    .width_select_in(width_select_out), .q_out(mem_q_in));
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // value compare
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // latency compare against a range of edges
  task automatic chk_n(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask
  // one request at a falling edge; n counts edges to the write done or read valid pulse
  task automatic op(input logic wr, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    int i;
    for (i = 0; i < 50 && ready_out !== 1'b1; i++) @(negedge clk_in);
    req_in = 1'b1;
    write_in = wr;
    addr_in = a;
    wdata_in = d;
    @(posedge clk_in);
    @(negedge clk_in);
    req_in = 1'b0;
    for (n = 0; n < 50 && (wr ? wdone_out : rvalid_out) !== 1'b1; n++)
      @(negedge clk_in);
    if (i == 50 || n == 50) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] d);
    op(1'b1, a, d);
    chk_n(n, 5, 5);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [3:0] e);
    op(1'b0, a, 4'h0);
    chk_n(n, 8, 10);
    chk_v(8'(rdata_out), 8'(e));
  endtask
  // idle pin levels straight after reset
  task automatic t_reset();
    chk_v({1'b0, mem_sel_n_out, mem_we_n_out, mem_oe_n_out, ready_out,
      width_select_out, rvalid_out, wdone_out}, 8'h78);
    $display("done t_reset");
  endtask
  // one-bit words at both ends of the range, back to back
  task automatic t_narrow();
    wr(22'h3f_ffff, 4'h1);
    wr(22'h00_0000, 4'he);
    rd(22'h3f_ffff, 4'h1);
    rd(22'h00_0000, 4'h0);
    wr(22'h3f_ffff, 4'h0);
    rd(22'h3f_ffff, 4'h0);
    $display("done t_narrow");
  endtask
  // four-bit words
  task automatic t_wide();
    wide_mode_in = 1'b1;
    // the pin follows only once the read's float wait has ended
    repeat (6) @(negedge clk_in);
    chk_v(8'(width_select_out), 8'h01);
    wr(22'h0f_ffff, 4'ha);
    wr(22'h00_0000, 4'h5);
    rd(22'h0f_ffff, 4'ha);
    rd(22'h00_0000, 4'h5);
    wide_mode_in = 1'b0;
    repeat (3) @(negedge clk_in);
    $display("done t_wide");
  endtask
  // a held request is taken once in idle; address and data changed while busy are ignored
  task automatic t_refuse();
    wr(22'h00_0001, 4'h1);
    req_in = 1'b1;
    write_in = 1'b1;
    addr_in = 22'h00_0002;
    wdata_in = 4'h1;
    @(posedge clk_in);
    @(negedge clk_in);
    addr_in = 22'h00_0001;
    wdata_in = 4'h0;
    repeat (2) @(negedge clk_in);
    req_in = 1'b0;
    rd(22'h00_0001, 4'h1);
    rd(22'h00_0002, 4'h1);
    $display("done t_refuse");
  endtask
  // slow memory answer inside the access time
  task automatic t_slow();
    asr_sram_model_inst.dly_ns = 11;
    rd(22'h00_0001, 4'h1);
    asr_sram_model_inst.dly_ns = 2;
    $display("done t_slow");
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    t_reset();
    t_narrow();
    t_wide();
    t_refuse();
    t_slow();
    report_and_stop();
  end
endmodule // tb_async_static_ram_4mbit
bind asr_ctrl asr_ctrl_asserts #(.AW(AW), .DW(DW)) asr_ctrl_asserts_inst (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .mem_addr_out(mem_addr_out),
  .mem_sel_n_out(mem_sel_n_out), .mem_we_n_out(mem_we_n_out),
  .mem_oe_n_out(mem_oe_n_out), .mem_d_out(mem_d_out),
  .width_select_out(width_select_out), .wdone_out(wdone_out));
